//--- common/rgc_regs.vh
/*
  Register map, field positions, gain-state constants and timing counts
  for the receiver gain control block.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef RGC_REGS_VH
`define RGC_REGS_VH
// ==========================================
// Register byte addresses
`define RGC_ADDR_MODE      4'h0
`define RGC_ADDR_STATUS    4'h4
`define RGC_ADDR_LEVEL     4'h8
`define RGC_ADDR_DEMOD     4'hC
// ==========================================
// Mode word field positions (bit n of the mode word is index n-1)
`define RGC_BIT_AGC_EN     2
`define RGC_BIT_RX_CP_CUR  5
`define RGC_BIT_TX_CP_CUR  6
`define RGC_BIT_RX_CP_POL  7
`define RGC_BIT_TX_CP_POL  8
`define RGC_BIT_MIX_LO     9
`define RGC_BIT_MIX_HI     10
`define RGC_BIT_BB_LO      11
`define RGC_BIT_BB_HI      13
`define RGC_BIT_NO_RESET   14
`define RGC_BIT_DIGITAL    16
`define RGC_BIT_PER_LO     20
`define RGC_BIT_PER_HI     21
`define RGC_MODE_RESET     22'h000000
`define RGC_MODE_MASK      22'h3FFFFF
// ==========================================
// Gain states
`define RGC_STATE_MAX      4'h8
// ==========================================
// Evaluation period: base time in microseconds at the nominal bandwidth
`define RGC_TSE_BASE_US    7000
`define RGC_CLK_MHZ        10
`define RGC_TSE_BASE_CYC   (`RGC_TSE_BASE_US * `RGC_CLK_MHZ)
`endif

//--- rtl/rgc_gain_table.v
/*
  Gain table: attenuation per stage for an automatic gain state, with the
  thresholds for entering and leaving a state.
  Assumes a combinational consumer; levels are signed dBm.
*/
`timescale 1ns/1ps
`default_nettype none
module rgc_gain_table
(
  input  wire [3:0]        state,
  output reg  [1:0]        mixer_att,
  output reg  [4:0]        stage_att,
  output reg  signed [7:0] up_thresh,
  output reg  signed [7:0] down_thresh
);
  // stage_att bits: {pad, bb4, bb3, bb2, bb1}; mixer_att in 10 dB units
  always @*
  begin
    mixer_att   = 2'h0;
    stage_att   = 5'h00;
    up_thresh   = 8'sh7F;
    down_thresh = 8'sh80;
    case (state)
      4'h0: begin up_thresh = -8'sd86; end
      // Leaving a state uses its own falling threshold; entering it uses the rising threshold of the state below
      4'h1: begin stage_att = 5'h02; up_thresh = -8'sd76; down_thresh = -8'sd92; end
      4'h2: begin stage_att = 5'h06; up_thresh = -8'sd66; down_thresh = -8'sd82; end
      4'h3: begin stage_att = 5'h06; mixer_att = 2'h1; up_thresh = -8'sd56; down_thresh = -8'sd72; end
      4'h4: begin stage_att = 5'h07; mixer_att = 2'h1; up_thresh = -8'sd46; down_thresh = -8'sd62; end
      4'h5: begin stage_att = 5'h07; mixer_att = 2'h2; up_thresh = -8'sd36; down_thresh = -8'sd52; end
      4'h6: begin stage_att = 5'h0F; mixer_att = 2'h2; up_thresh = -8'sd26; down_thresh = -8'sd42; end
      4'h7: begin stage_att = 5'h1F; mixer_att = 2'h2; up_thresh = -8'sd16; down_thresh = -8'sd32; end
      4'h8: begin stage_att = 5'h1F; mixer_att = 2'h3; down_thresh = -8'sd22; end // see [R3]
      default: begin stage_att = 5'h1F; mixer_att = 2'h3; end
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/rgc_period_timer.v
/*
  Evaluation period timer: emits a one-cycle tick every period.
  Assumes a synchronous active-low reset and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rgc_regs.vh"
module rgc_period_timer
#(
  parameter [31:0] BASE_CYCLES = `RGC_TSE_BASE_CYC
)
(
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       enable,
  input  wire [1:0] code,
  output reg        tick
);
  reg  [31:0] count;
  wire [31:0] limit = (BASE_CYCLES << code) - 32'h1; // see [R10]
  always @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      count <= 32'h0;
      tick  <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/rgc_top.v
/*
  Receiver gain control with AXI4-Lite register access: automatic stepped
  gain with hysteresis, manual decode, gain reset on write, charge pump
  selects and demodulator output formatting.
  Assumes an AXI4-Lite master on aclk and a quantised level input from an
  asynchronous measuring circuit.
*/
// Implementation choices: the AXI4-Lite register port and the register offsets.
// Function
// [R1] Enable bit one: device picks its gain stages from signal strength.
// [R2] Nine states, rising and falling thresholds differ for hysteresis.
// [R3] Each step adds 10 dB in a fixed stage order.
// [R4] Automatic mode ignores manual mixer and baseband fields.
// [R5] Manual mode sets every stage from the manual fields.
// [R6] Mixer field 00,01,10,11 gives 30,20,10,0 dB.
// [R7] Baseband/pad field decodes to the six tabled stage settings.
// [R8] Evaluation period only acts in automatic mode.
// [R9] Level reassessed once per evaluation period set by two bits.
// [R10] Period codes give 7, 14, 28, 56 ms, bandwidth scaled.
// [R11] Host picks a period above twice the integration time.
// [R12] First variant: any write in automatic mode returns gain to maximum.
// [R13] Second variant: no-reset bit keeps the gain state across writes.
// [R14] Host sets correction polarity bit for the inverted varactor wiring.
// [R15] Each charge pump selects 0.2 mA or 1 mA current.
// [R16] Host keeps pump polarity normal except for inverted external tuning.
// [R17] Format bit picks sliced digital or bypassed analog output.
// [R18] Digital data: one for positive deviation, zero for negative.
// [R19] Transmit one gives negative deviation, zero positive.
// [R20] Analog output inverted relative to deviation.
// [R21] Baseband codes 110 and 111 give zero attenuation.
// [R22] Level sampled each period; at most one step per evaluation.
`timescale 1ns/1ps
`default_nettype none
`include "rgc_regs.vh"
module rgc_top
#(
  parameter        VARIANT_NO_RESET = 1'b1,
  parameter [31:0] BASE_CYCLES      = `RGC_TSE_BASE_CYC
)
(
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [3:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [3:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire signed [7:0] signal_level,
  input  wire              demod_sign,
  input  wire [7:0]        demod_sample,
  output reg  [1:0]        mixer_att,
  output reg  [4:0]        stage_att,
  output reg               rx_cp_high,
  output reg               tx_cp_high,
  output reg               rx_cp_invert,
  output reg               tx_cp_invert,
  output reg               tx_mod_invert,
  output reg               demod_output_digital,
  output reg               demod_output_pin,
  output reg  [7:0]        demod_analog
);
  // ==========================================
  // Bus slave
  reg  [21:0] mode;
  reg  [3:0]  gain_state;
  reg  [3:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  reg         write_pulse;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire       aw_fire = s_axi_awvalid && s_axi_awready;
  wire       w_fire  = s_axi_wvalid && s_axi_wready;
  wire       have_aw = aw_held || aw_fire;
  wire       have_w  = w_held || w_fire;
  wire [3:0] cur_aw  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] cur_w  = w_held ? w_data : s_axi_wdata;
  wire [3:0] cur_s   = w_held ? w_strb : s_axi_wstrb;
  wire       do_write = have_aw && have_w && !s_axi_bvalid;

  function [21:0] merge;
    input [21:0] old;
    input [31:0] data;
    input [3:0]  strb;
    reg   [31:0] wide;
    begin
      wide = {10'h000, old};
      if (strb[0]) wide[7:0]   = data[7:0];
      if (strb[1]) wide[15:8]  = data[15:8];
      if (strb[2]) wide[23:16] = data[23:16];
      if (strb[3]) wide[31:24] = data[31:24];
      merge = wide[21:0] & `RGC_MODE_MASK;
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      mode         <= `RGC_MODE_RESET;
      write_pulse  <= 1'b0;
    end
    else
    begin
      write_pulse <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        write_pulse  <= 1'b1;
        if (cur_aw == `RGC_ADDR_MODE)
        begin
          mode        <= merge(mode, cur_w, cur_s);
          s_axi_bresp <= 2'h0;
        end
        else
          s_axi_bresp <= 2'h2;
      end
      else
      begin
        if (aw_fire)
        begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_fire)
        begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  // ==========================================
  // Level and demodulator input synchronisers
  reg [7:0] level_meta;
  reg [7:0] level_sync;
  reg [7:0] level_prev;
  reg [7:0] level_hold;
  reg [1:0] sign_sync;
  reg [7:0] samp_meta;
  reg [7:0] samp_sync;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_meta <= 8'h80;
      level_sync <= 8'h80;
      level_prev <= 8'h80;
      level_hold <= 8'h80;
      sign_sync  <= 2'h0;
      samp_meta  <= 8'h80;
      samp_sync  <= 8'h80;
    end
    else
    begin
      level_meta <= signal_level;
      level_sync <= level_meta;
      // Multi-bit word: accept only when two samples agree
      level_prev <= level_sync;
      if (level_sync == level_prev)
        level_hold <= level_sync;
      sign_sync  <= {sign_sync[0], demod_sign};
      samp_meta  <= demod_sample;
      samp_sync  <= samp_meta;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_rvalid <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      s_axi_rvalid <= 1'b1;
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `RGC_ADDR_MODE:   s_axi_rdata <= {10'h000, mode};
        `RGC_ADDR_STATUS: s_axi_rdata <= {21'h0, mixer_att, stage_att, gain_state};
        `RGC_ADDR_LEVEL:  s_axi_rdata <= {{24{level_hold[7]}}, level_hold};
        `RGC_ADDR_DEMOD:  s_axi_rdata <= {23'h0, demod_output_pin, demod_analog};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end

  // ==========================================
  // Automatic gain state machine
  wire       agc_on   = mode[`RGC_BIT_AGC_EN];
  wire [1:0] per_code = mode[`RGC_BIT_PER_HI:`RGC_BIT_PER_LO];
  wire       eval_tick;
  wire [1:0] tab_mixer;
  wire [4:0] tab_stage;
  wire signed [7:0] up_thresh;
  wire signed [7:0] down_thresh;
  wire signed [7:0] level_now = level_hold;

  rgc_period_timer #(.BASE_CYCLES(BASE_CYCLES)) u_timer
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (agc_on),     // see [R8]
    .code    (per_code),   // see [R9]
    .tick    (eval_tick)
  );

  rgc_gain_table u_table
  (
    .state       (gain_state),
    .mixer_att   (tab_mixer),
    .stage_att   (tab_stage),
    .up_thresh   (up_thresh),
    .down_thresh (down_thresh)
  );

  wire keep_gain = VARIANT_NO_RESET && mode[`RGC_BIT_NO_RESET];

  always @(posedge aclk)
  begin
    if (!aresetn || !agc_on)
      gain_state <= 4'h0;
    else if (write_pulse && !keep_gain)
      gain_state <= 4'h0;                                           // see [R12] [R13]
    else if (eval_tick)
    begin
      if (gain_state != `RGC_STATE_MAX && level_now > up_thresh)
        gain_state <= gain_state + 4'h1;                            // see [R2] [R22]
      else if (gain_state != 4'h0 && level_now < down_thresh)
        gain_state <= gain_state - 4'h1;                            // see [R2] [R22]
    end
  end

  // ==========================================
  // Manual decode
  function [4:0] bb_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0:    bb_decode = 5'h1F;
        3'h1:    bb_decode = 5'h0F;
        3'h2:    bb_decode = 5'h07;
        3'h3:    bb_decode = 5'h06;
        3'h4:    bb_decode = 5'h02;
        default: bb_decode = 5'h00; // see [R21]
      endcase
    end
  endfunction

  wire [1:0] man_mixer = ~mode[`RGC_BIT_MIX_HI:`RGC_BIT_MIX_LO];    // see [R6]
  wire [4:0] man_stage = bb_decode(mode[`RGC_BIT_BB_HI:`RGC_BIT_BB_LO]); // see [R7]

  // ==========================================
  // Outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mixer_att            <= 2'h0;
      stage_att            <= 5'h00;
      rx_cp_high           <= 1'b0;
      tx_cp_high           <= 1'b0;
      rx_cp_invert         <= 1'b0;
      tx_cp_invert         <= 1'b0;
      tx_mod_invert        <= 1'b1;
      demod_output_digital <= 1'b0;
      demod_output_pin     <= 1'b0;
      demod_analog         <= 8'h80;
    end
    else
    begin
      mixer_att            <= agc_on ? tab_mixer : man_mixer;       // see [R1] [R4] [R5]
      stage_att            <= agc_on ? tab_stage : man_stage;       // see [R1] [R4] [R5]
      rx_cp_high           <= mode[`RGC_BIT_RX_CP_CUR];             // see [R15]
      tx_cp_high           <= mode[`RGC_BIT_TX_CP_CUR];             // see [R15]
      rx_cp_invert         <= mode[`RGC_BIT_RX_CP_POL];
      tx_cp_invert         <= mode[`RGC_BIT_TX_CP_POL];
      tx_mod_invert        <= 1'b1;                                 // see [R19]
      demod_output_digital <= mode[`RGC_BIT_DIGITAL];               // see [R17]
      demod_output_pin     <= mode[`RGC_BIT_DIGITAL] && sign_sync[1]; // see [R18]
      demod_analog         <= mode[`RGC_BIT_DIGITAL] ? 8'h80 : ~samp_sync; // see [R20]
    end
  end
endmodule
`default_nettype wire

//--- testbench/rgc_host.sv
/* Host model: AXI4-Lite master programming the mode word.
   Assumes callers enter a task at or after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module rgc_host
(
  input  wire logic        aclk,
  output var  logic [3:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [3:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  // Both pump polarity bits stay clear except in the register test, which sets them
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Handshakes are judged on values settled before the edge that takes them
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_pend;
    logic w_pend;
    logic aw_go;
    logic w_go;
    logic b_seen;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    b_seen = 1'b0;
    while (!b_seen)
    begin
      @(negedge aclk);
      aw_go = aw_pend && s_axi_awready;
      w_go = w_pend && s_axi_wready;
      b_seen = s_axi_bvalid;
      @(posedge aclk);
      if (aw_go)
      begin
        s_axi_awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_go)
      begin
        s_axi_wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ar_pend;
    logic ar_go;
    logic r_seen;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar_pend = 1'b1;
    r_seen = 1'b0;
    d = '0;
    while (!r_seen)
    begin
      @(negedge aclk);
      ar_go = ar_pend && s_axi_arready;
      r_seen = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ar_go)
      begin
        s_axi_arvalid <= 1'b0;
        ar_pend = 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/rgc_top_chk.sv
/* Checker for the gain control block, fed from its top-level ports.
   Assumes whole-word mode writes with address and data offered together. */
`timescale 1ns/1ps
`default_nettype none
module rgc_top_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        demod_sign,
  input wire logic [7:0]  demod_sample,
  input wire logic [1:0]  mixer_att,
  input wire logic [4:0]  stage_att,
  input wire logic        rx_cp_high,
  input wire logic        tx_cp_high,
  input wire logic        rx_cp_invert,
  input wire logic        tx_cp_invert,
  input wire logic        tx_mod_invert,
  input wire logic        demod_output_digital,
  input wire logic        demod_output_pin,
  input wire logic [7:0]  demod_analog
);
  // ==========================================
  // Shadow of the mode word and its age
  logic [21:0] mode;
  logic [2:0]  age;
  wire         aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 4'h0;
  wire         top = mixer_att == 2'h3 && stage_att == 5'h1F;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || aw_hs)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
    if (!aresetn)
      mode <= 22'h000000;
    else if (aw_hs)
      mode <= s_axi_wdata[21:0];
  end

  function automatic logic [4:0] exp_stage(input logic [2:0] c);
    case (c)
      3'h0: return 5'h1F;
      3'h1: return 5'h0F;
      3'h2: return 5'h07;
      3'h3: return 5'h06;
      3'h4: return 5'h02;
      default: return 5'h00;
    endcase
  endfunction

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================
  // Properties
  manual_mix_a: assert property (age > 3'h3 && !mode[2] |-> mixer_att == 2'h3 - mode[10:9])
    else $error("manual mixer attenuation wrong");
  manual_bb_a: assert property (age > 3'h3 && !mode[2] |-> stage_att == exp_stage(mode[13:11]))
    else $error("manual stage attenuation wrong");
  pump_sel_a: assert property (age > 3'h3 |-> {rx_cp_high, tx_cp_high, rx_cp_invert, tx_cp_invert,
    demod_output_digital} == {mode[5], mode[6], mode[7], mode[8], mode[16]})
    else $error("pump or format select wrong");
  mod_inv_a: assert property (age > 3'h3 |-> tx_mod_invert == 1'b1)
    else $error("modulator polarity wrong");
  digital_out_a: assert property (age > 3'h3 && mode[16] |-> demod_output_pin == $past(demod_sign, 3))
    else $error("sliced data wrong");
  analog_out_a: assert property (age > 3'h3 && !mode[16] |-> demod_analog == ~$past(demod_sample, 3)
    && !demod_output_pin)
    else $error("analog output wrong");
  gain_reset_a: assert property (aw_hs && mode[2] && !mode[14] && s_axi_wdata[2] && !s_axi_wdata[14]
    |-> ##[1:3] mixer_att == 2'h0 && stage_att[4:2] == 3'h0)
    else $error("gain not reset by write");
  keep_gain_a: assert property (aw_hs && top && mode[2] && mode[14] && s_axi_wdata[2] && s_axi_wdata[14]
    |=> $stable({mixer_att, stage_att})[*3])
    else $error("gain lost across write");

  cover property (aw_hs && s_axi_wdata[2]);
  cover property (top && mode[2]);
  cover property (age > 3'h3 && mode[16] && demod_output_pin);
endmodule

bind rgc_top rgc_top_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .demod_sign, .demod_sample, .mixer_att, .stage_att, .rx_cp_high, .tx_cp_high,
  .rx_cp_invert, .tx_cp_invert, .tx_mod_invert, .demod_output_digital, .demod_output_pin, .demod_analog);
`default_nettype wire

//--- testbench/tb.sv
/* Self-checking bench for the gain control block.
   Assumes the host model and the bound checker alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic signed [7:0] signal_level = 8'sd0;
  logic demod_sign = 1'b0;
  logic [7:0] demod_sample = 8'h80;
  wire [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp, mixer_att;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [4:0] stage_att;
  wire [7:0] demod_analog;
  wire rx_cp_high, tx_cp_high, rx_cp_invert, tx_cp_invert, tx_mod_invert, demod_output_digital, demod_output_pin;
  int num_errors = 0;
  int compares = 0;
  logic [4:0] bb_tbl [8] = '{5'h1F, 5'h0F, 5'h07, 5'h06, 5'h02, 5'h00, 5'h00, 5'h00};
  // Period code 0 in both AGC words keeps the period above the integration time; the slow-period step sets code 3
  localparam logic [31:0] AGC_KEEP = 32'h0000_6E04;
  localparam logic [31:0] AGC_RST = 32'h0000_2E04;

  assign s_axi_wstrb = 4'hF;
  always #50 aclk = ~aclk;

  rgc_top #(.VARIANT_NO_RESET(1'b1), .BASE_CYCLES(32'd20)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .signal_level, .demod_sign, .demod_sample, .mixer_att, .stage_att, .rx_cp_high, .tx_cp_high,
    .rx_cp_invert, .tx_cp_invert, .tx_mod_invert, .demod_output_digital, .demod_output_pin, .demod_analog);

  rgc_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_manual;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(4'h0, 32'((i << 11) | ((i & 3) << 9)));
      step(30);
      check("mixer_att", 32'(3 - (i & 3)), 32'(mixer_att));
      check("stage_att", 32'(bb_tbl[i]), 32'(stage_att));
    end
  endtask

  task automatic t_agc;
    @(posedge aclk);
    signal_level <= -8'sd80;
    host.wr(4'h0, AGC_KEEP);
    step(60);
    check("stage_att", 32'h02, 32'(stage_att));
    check("mixer_att", 32'h0, 32'(mixer_att));
    signal_level <= 8'sd0;
    step(220);
    check("top gain", 32'h3F, 32'({mixer_att, stage_att[3:0]} | {1'b0, stage_att[4]}));
    host.wr(4'h0, AGC_KEEP);
    step(2);
    check("kept gain", 32'h7F, 32'({mixer_att, stage_att}));
    host.wr(4'h0, AGC_RST);
    step(200);
    host.wr(4'h0, AGC_RST | 32'h0030_0000);
    step(3);
    check("reset gain", 32'h0, 32'({mixer_att, stage_att[4:2]}));
    step(140);
    check("slow period", 32'h0, 32'({mixer_att, stage_att & 5'h1D}));
  endtask

  task automatic t_demod;
    host.wr(4'h0, 32'h0001_0000);
    demod_sign <= 1'b1;
    step(5);
    check("pin one", 32'h1, 32'(demod_output_pin));
    check("digital flag", 32'h1, 32'(demod_output_digital));
    demod_sign <= 1'b0;
    step(5);
    check("pin zero", 32'h0, 32'(demod_output_pin));
    host.wr(4'h0, 32'h0);
    demod_sample <= 8'h30;
    step(5);
    check("analog", 32'h0CF, 32'({demod_output_pin, demod_analog}));
    check("mod invert", 32'h1, 32'(tx_mod_invert));
  endtask

  task automatic t_regs;
    logic [31:0] d;
    host.wr(4'h0, 32'hFFC0_01E0);
    step(3);
    check("pumps", 32'hF, 32'({rx_cp_high, tx_cp_high, rx_cp_invert, tx_cp_invert}));
    host.rd(4'h0, d);
    check("mode word", 32'h0000_01E0, d);
    host.rd(4'h4, d);
    check("status word", 32'h0000_07F0, d);
    host.wr(4'h4, 32'h0000_0000);
    check("bresp", 32'h2, 32'(s_axi_bresp));
    host.rd(4'h0, d);
    check("mode kept", 32'h0000_01E0, d);
    host.rd(4'h2, d);
    check("rresp", 32'h2, 32'(s_axi_rresp));
    check("unmapped data", 32'h0, d);
    signal_level <= -8'sd50;
    step(8);
    host.rd(4'h8, d);
    check("level word", 32'hFFFF_FFCE, d);
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    step(30);
    check("reset mixer", 32'h3, 32'(mixer_att));
    t_manual();
    t_agc();
    t_demod();
    t_regs();
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
